// file: design/wdg_guard.sv
// Purpose: watchdog with write-protected mode and clear registers
// Assumes: cpu strobes are synchronous to core_clk, one request at a time
// Notes:   internal reset stays asserted until sys_rst
//
// Contract
// - mode register byte write inserts one wait cycle
// - unstoppable option forces upper mode bits 011
// - mode register takes one byte write only
// - second mode write raises internal reset
// - violation waits for running source clock
// - software stop is permanent, without reset
// - wrong clear key raises internal reset
// - bit instruction on clear raises reset
// - clear register reads fixed non-key pattern
`timescale 1ns/1ps
`default_nettype none
module wdg_guard
	import wdg_pkg::*;
#(
	parameter int OVF_TICKS_BASE = OVF_TICKS_DEF
)(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	// mask option and source clock status
	input  wire logic       osc_unstoppable,
	input  wire logic       src_clk_run,
	// cpu access port
	input  wire wdg_req_t   bus_in,
	output logic [7:0]      bus_rdata_q,
	output logic            bus_wait_q,
	output logic            bus_ack_q,
	// reset request to the reset generator
	output logic            int_reset_q,
	// status
	output logic            wdg_stopped_q
);
	// ------------------------------------------------------------
	// access decode
	// ------------------------------------------------------------
	wdg_acc_st_t st_q;
	wdg_acc_st_t st_d;
	logic [7:0]  mode_q;
	logic        mode_written_q;
	logic        pend_q;
	logic        ovf;

	// requests are only taken in idle; others are dropped on purpose
	wire take       = bus_in.req && (st_q == ST_IDLE);
	wire take_mode  = take && (bus_in.sel == SEL_MODE);
	wire take_clr   = take && (bus_in.sel == SEL_CLEAR);
	wire mode_wr    = take_mode && bus_in.we && !bus_in.bitop;
	wire mode_store = mode_wr && !mode_written_q;
	wire mode_again = mode_wr && mode_written_q;
	wire clr_wr     = take_clr && bus_in.we && !bus_in.bitop;
	wire key_ok     = clr_wr && (bus_in.wdata == CLEAR_KEY);
	wire key_bad    = clr_wr && (bus_in.wdata != CLEAR_KEY);
	wire clr_bitop  = take_clr && bus_in.bitop;
	wire viol       = mode_again || key_bad || clr_bitop || ovf;

	// upper bits are pinned when the oscillator cannot be stopped
	wire [2:0] fix_bits = osc_unstoppable ? MODE_FIX_VAL
	                                      : bus_in.wdata[MODE_FIX_MSB:MODE_FIX_LSB];
	wire [7:0] mode_new = {fix_bits, bus_in.wdata[MODE_STOP_BIT:0]};
	wire       stop_req = mode_store && !osc_unstoppable
	                      && bus_in.wdata[MODE_STOP_BIT];
	wire [7:0] rd_val   = (bus_in.sel == SEL_CLEAR) ? CLEAR_READ_VAL : mode_q;
	wire       cnt_run  = src_clk_run && !wdg_stopped_q;

	// ------------------------------------------------------------
	// access sequencing
	// ------------------------------------------------------------
	// a mode byte write stretches the access by one wait cycle
	always_comb
	begin
		st_d = st_q;
		unique case (st_q)
			ST_IDLE: if (take) st_d = mode_wr ? ST_WAIT : ST_DONE;
			ST_WAIT: st_d = ST_DONE;
			ST_DONE: st_d = ST_IDLE;
			default: st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_q       <= ST_IDLE;
			bus_wait_q <= 1'b0;
			bus_ack_q  <= 1'b0;
		end
		else
		begin
			st_q       <= st_d;
			bus_wait_q <= (st_d == ST_WAIT);
			bus_ack_q  <= (st_d == ST_DONE);
		end
	end

	// read data captured when the request is taken
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			bus_rdata_q <= 8'h00;
		else if (take && !bus_in.we)
			bus_rdata_q <= rd_val;
	end

	// ------------------------------------------------------------
	// mode register, one shot
	// ------------------------------------------------------------
	// bit-instruction writes to mode are not stored and do not use up the shot
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			mode_q         <= MODE_RST;
			mode_written_q <= 1'b0;
			wdg_stopped_q  <= 1'b0;
		end
		else
		begin
			if (mode_store)
			begin
				mode_q         <= mode_new;
				mode_written_q <= 1'b1;
			end
			if (stop_req)
				wdg_stopped_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// counter and reset request
	// ------------------------------------------------------------
	wdg_counter #(
		.OVF_TICKS_BASE (OVF_TICKS_BASE)
	) u_cnt (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.run      (cnt_run),
		.clr      (key_ok),
		.sel      (mode_q[MODE_SEL_MSB:MODE_SEL_LSB]),
		.ovf_q    (ovf)
	);

	// violations wait while the source clock is stopped; set is sticky
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pend_q      <= 1'b0;
			int_reset_q <= 1'b0;
		end
		else
		begin
			if (viol)
				pend_q <= 1'b1;
			if ((pend_q || viol) && src_clk_run)
				int_reset_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_wait_then_ack;
		bus_wait_q && !bus_ack_q ##1 bus_ack_q && !bus_wait_q;
	endsequence

	property p_mode_wait;
		@(posedge core_clk) disable iff (sys_rst)
		mode_wr |=> s_wait_then_ack;
	endproperty
	a_mode_wait: assert property (p_mode_wait) else $error("mode write lacks wait cycle");

	property p_clr_nowait;
		@(posedge core_clk) disable iff (sys_rst)
		take_clr |=> bus_ack_q && !bus_wait_q;
	endproperty
	a_clr_nowait: assert property (p_clr_nowait) else $error("clear access got wait");

	property p_fixed_bits;
		@(posedge core_clk) disable iff (sys_rst)
		mode_store && osc_unstoppable |=> mode_q[MODE_FIX_MSB:MODE_FIX_LSB] == MODE_FIX_VAL;
	endproperty
	a_fixed_bits: assert property (p_fixed_bits) else $error("upper mode bits not pinned");

	property p_mode_frozen;
		@(posedge core_clk) disable iff (sys_rst)
		mode_written_q |=> $stable(mode_q) && mode_written_q;
	endproperty
	a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed after first write");

	property p_second_write;
		@(posedge core_clk) disable iff (sys_rst)
		mode_again |=> pend_q;
	endproperty
	a_second_write: assert property (p_second_write) else $error("second mode write not flagged");

	property p_defer;
		@(posedge core_clk) disable iff (sys_rst)
		!src_clk_run && !int_reset_q |=> !int_reset_q;
	endproperty
	a_defer: assert property (p_defer) else $error("reset raised with source clock stopped");

	property p_resume;
		@(posedge core_clk) disable iff (sys_rst)
		pend_q && src_clk_run |=> int_reset_q;
	endproperty
	a_resume: assert property (p_resume) else $error("pending reset not raised on resume");

	property p_stop_sticky;
		@(posedge core_clk) disable iff (sys_rst)
		$rose(wdg_stopped_q) |-> !pend_q ##1 wdg_stopped_q [*4];
	endproperty
	a_stop_sticky: assert property (p_stop_sticky) else $error("software stop not held");

	property p_bad_key;
		@(posedge core_clk) disable iff (sys_rst)
		key_bad |=> pend_q && (int_reset_q || !$past(src_clk_run));
	endproperty
	a_bad_key: assert property (p_bad_key) else $error("wrong key not flagged");

	property p_clr_bitop;
		@(posedge core_clk) disable iff (sys_rst)
		clr_bitop |=> pend_q;
	endproperty
	a_clr_bitop: assert property (p_clr_bitop) else $error("bit op on clear not flagged");

	property p_clr_read;
		@(posedge core_clk) disable iff (sys_rst)
		take_clr && !bus_in.we |=> bus_rdata_q == CLEAR_READ_VAL && bus_ack_q;
	endproperty
	a_clr_read: assert property (p_clr_read) else $error("clear read pattern wrong");

	property p_overflow;
		@(posedge core_clk) disable iff (sys_rst)
		ovf |=> pend_q;
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow not flagged");
endmodule // wdg_guard
`default_nettype wire

// file: common/wdg_pkg.sv
// Purpose: shared constants and types of the write-guarded watchdog
// Assumes: one 25 MHz core clock, byte-wide register port
// Notes:   every offset, field position, reset value and count lives here
`default_nettype none
package wdg_pkg;
	// ------------------------------------------------------------
	// register selects and layout
	// ------------------------------------------------------------
	localparam logic       SEL_MODE       = 1'b0;    // watchdog_mode_register
	localparam logic       SEL_CLEAR      = 1'b1;    // watchdog_clear_register
	localparam int         MODE_FIX_MSB   = 7;
	localparam int         MODE_FIX_LSB   = 5;
	localparam logic [2:0] MODE_FIX_VAL   = 3'h3;    // bits 7..5 = 0,1,1
	localparam int         MODE_STOP_BIT  = 4;       // watchdog_stop_bit
	localparam int         MODE_SEL_MSB   = 1;
	localparam int         MODE_SEL_LSB   = 0;
	localparam logic [7:0] MODE_RST       = 8'h63;   // fixed bits, run, longest interval
	localparam logic [7:0] CLEAR_KEY      = 8'hac;
	localparam logic [7:0] CLEAR_READ_VAL = 8'h9a;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 40;
	localparam int TICK_NS        = 1000;                          // one count tick
	localparam int TICK_CYC       = TICK_NS / CLK_PERIOD_NS;
	localparam int TICK_W         = 5;
	localparam int CNT_W          = 16;
	localparam int OVF_TICKS_DEF  = 1024;                          // shortest interval in ticks

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic       req;     // access request, held until ack is seen at an edge
		logic       we;      // 1 write, 0 read
		logic       sel;     // SEL_MODE or SEL_CLEAR
		logic       bitop;   // access comes from a 1-bit manipulation instruction
		logic [7:0] wdata;
	} wdg_req_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_WAIT = 2'h1,
		ST_DONE = 2'h3
	} wdg_acc_st_t;
endpackage : wdg_pkg
`default_nettype wire

// file: design/wdg_counter.sv
// Purpose: tick divider and overflow counter of the watchdog
// Assumes: run is low whenever the source clock is stopped or software stopped it
// Notes:   the count is held, not cleared, while run is low
`timescale 1ns/1ps
`default_nettype none
module wdg_counter
	import wdg_pkg::*;
#(
	parameter int OVF_TICKS_BASE = OVF_TICKS_DEF
)(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	// control
	input  wire logic       run,
	input  wire logic       clr,
	input  wire logic [1:0] sel,
	// event
	output logic            ovf_q
);
	logic [TICK_W-1:0] div_q;
	logic [CNT_W-1:0]  cnt_q;
	wire               tick   = run && (div_q == TICK_W'(TICK_CYC - 1));
	wire  [CNT_W-1:0]  limit  = CNT_W'((OVF_TICKS_BASE << sel) - 1);
	// at or past the limit: a shorter interval chosen mid-count must not wait for a 16-bit wrap
	wire               at_top = tick && (cnt_q >= limit);

	// divider restarts with the count so a clear gives a full interval
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			div_q <= '0;
		else if (clr || tick)
			div_q <= '0;
		else if (run)
			div_q <= div_q + TICK_W'(1);
	end

	// interval counter; clear beats the tick
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cnt_q <= '0;
			ovf_q <= 1'b0;
		end
		else
		begin
			ovf_q <= at_top && !clr;
			if (clr || at_top)
				cnt_q <= '0;
			else if (tick)
				cnt_q <= cnt_q + CNT_W'(1);
		end
	end
endmodule // wdg_counter
`default_nettype wire

// file: verif/wdg_cpu_model.sv
// Purpose: cpu core model issuing byte and bit accesses to the guard
// Assumes: one access at a time, request held until ack is sampled high at an edge
// Notes:   the next access starts at the edge after ack
`timescale 1ns/1ps
`default_nettype none
module wdg_cpu_model
	import wdg_pkg::*;
(
	// clock
	input  wire logic       core_clk,
	// register port
	output var  wdg_req_t   bus_o,
	input  wire logic [7:0] rdata,
	input  wire logic       wait_i,
	input  wire logic       ack
);
	initial bus_o = '0;

	// ------------------------------------------------------------
	// accesses
	// ------------------------------------------------------------
	// every access is one byte; the request stands until ack is seen at an edge, so a
	// busy guard sees it again but drops it, and nothing moves before the answer
	task automatic access(input logic we, input logic sel, input logic bitop, input logic [7:0] d,
		output logic [7:0] rd, output logic wt);
		int i;
		rd = 'x;
		wt = 1'b0;
		@(posedge core_clk);
		bus_o <= {1'b1, we, sel, bitop, d};
		@(posedge core_clk);
		// registered answers read right after an edge hold the values sampled at it
		for (i = 0; i < 4 && ack !== 1'b1; i++)
		begin
			wt |= wait_i;
			@(posedge core_clk);
		end
		if (ack === 1'b1)
			rd = rdata;
		bus_o.req <= 1'b0;
	endtask

	// legal mode write: fixed upper bits, byte access; no subsystem clock mode here, so never
	// written with the main oscillator stopped
	task automatic mode_wr(input logic [4:0] lo, output logic wt);
		logic [7:0] rd;
		access(1'b1, SEL_MODE, 1'b0, {MODE_FIX_VAL, lo}, rd, wt);
	endtask
endmodule // wdg_cpu_model
`default_nettype wire

// file: verif/tb_watchdog_write_guard.sv
// Purpose: self-checking bench of the write-guarded watchdog
// Assumes: overflow base shortened to 4 ticks, so 100 cycles at interval 0
// Notes:   each test starts from a fresh reset, the reset request is sticky
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) chk((a) === (b), m)
module tb_watchdog_write_guard;
	import wdg_pkg::*;
	logic       core_clk        = 1'b0;
	logic       sys_rst         = 1'b1;
	logic       osc_unstoppable = 1'b0;
	logic       src_clk_run     = 1'b1;
	wdg_req_t   bus_in;
	logic [7:0] bus_rdata_q, rd, key;
	logic       bus_wait_q, bus_ack_q, int_reset_q, wdg_stopped_q, wt, got;
	logic [4:0] lo;
	logic [2:0] hi;
	int         n_mismatch = 0, num_checks = 0, cyc = 0, k;
	integer     seed = 32'hb6cc;

	// ------------------------------------------------------------
	// clock, design, cpu model
	// ------------------------------------------------------------
	always #20 core_clk = ~core_clk;

	wdg_guard #(.OVF_TICKS_BASE(4)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.osc_unstoppable(osc_unstoppable), .src_clk_run(src_clk_run), .bus_in(bus_in),
		.bus_rdata_q(bus_rdata_q), .bus_wait_q(bus_wait_q), .bus_ack_q(bus_ack_q),
		.int_reset_q(int_reset_q), .wdg_stopped_q(wdg_stopped_q));

	wdg_cpu_model cpu (.core_clk(core_clk), .bus_o(bus_in), .rdata(bus_rdata_q),
		.wait_i(bus_wait_q), .ack(bus_ack_q));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t %s", $time, m);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic rst_dut(input logic unstop);
		@(posedge core_clk);
		sys_rst <= 1'b1;
		osc_unstoppable <= unstop;
		src_clk_run <= 1'b1;
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
	endtask

	// bounded watch for the reset request
	task automatic wait_rst(input int n, output logic g);
		int i;
		for (i = 0; i < n && int_reset_q !== 1'b1; i++)
		begin
			@(posedge core_clk);
			#1;
		end
		g = int_reset_q;
	endtask

	// a hang counts as a mismatch
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_mismatch++;
			complete_run();
		end
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial
	begin
		rst_dut(1'b0);
		cpu.access(1'b0, SEL_CLEAR, 1'b0, 8'h00, rd, wt);
		`CHK(rd, CLEAR_READ_VAL, "clear read");
		cpu.access(1'b0, SEL_MODE, 1'b0, 8'h00, rd, wt);
		`CHK(rd, MODE_RST, "mode reset value");
		lo = 5'($random(seed)) & 5'h0c;
		cpu.mode_wr(lo, wt);
		`CHK(wt, 1'b1, "mode write wait");
		cpu.access(1'b0, SEL_MODE, 1'b0, 8'h00, rd, wt);
		`CHK(rd, {MODE_FIX_VAL, lo}, "mode readback");
		// keys spaced under the 100-cycle overflow keep the reset away
		repeat (6)
		begin
			repeat (60) @(posedge core_clk);
			cpu.access(1'b1, SEL_CLEAR, 1'b0, CLEAR_KEY, rd, wt);
		end
		`CHK(int_reset_q, 1'b0, "keyed counter");
		cpu.mode_wr(lo, wt);
		wait_rst(3, got);
		`CHK(got, 1'b1, "second mode write");
		$display("test mode_once done");

		rst_dut(1'b1);
		hi = 3'($random(seed));
		if (hi == MODE_FIX_VAL)
			hi = 3'h0;
		cpu.access(1'b1, SEL_MODE, 1'b0, {hi, lo}, rd, wt);
		cpu.access(1'b0, SEL_MODE, 1'b0, 8'h00, rd, wt);
		`CHK(rd, {MODE_FIX_VAL, lo}, "upper bits forced");
		@(posedge core_clk);
		src_clk_run <= 1'b0;
		key = 8'($random(seed));
		if (key == CLEAR_KEY)
			key = 8'h00;
		cpu.access(1'b1, SEL_CLEAR, 1'b0, key, rd, wt);
		wait_rst(20, got);
		`CHK(got, 1'b0, "held while source stopped");
		@(posedge core_clk);
		src_clk_run <= 1'b1;
		wait_rst(3, got);
		`CHK(got, 1'b1, "wrong key fires on resume");
		$display("test deferred done");

		// bit instruction on clear, read and write alike
		for (k = 0; k < 2; k++)
		begin
			rst_dut(1'b0);
			cpu.access(k[0], SEL_CLEAR, 1'b1, CLEAR_KEY, rd, wt);
			wait_rst(3, got);
			`CHK(got, 1'b1, "bit op on clear");
		end
		$display("test bitop done");

		rst_dut(1'b0);
		cpu.mode_wr(5'h10, wt);
		wait_rst(300, got);
		`CHK(got, 1'b0, "stopped, no overflow");
		`CHK(wdg_stopped_q, 1'b1, "stop latched");
		$display("test soft_stop done");

		rst_dut(1'b0);
		cpu.mode_wr(5'h00, wt);
		wait_rst(75, got);
		`CHK(got, 1'b0, "early overflow");
		wait_rst(50, got);
		`CHK(got, 1'b1, "overflow reset");
		$display("test overflow done");
		complete_run();
	end
endmodule // tb_watchdog_write_guard
`default_nettype wire
